/* rtl/multimode_timer_pwm_unit.sv */
// Two full timer/counter units and six pulse-only timers behind an APB slave.
//
// Summary of operation
// (R1) Two full units each run as timer, PWM, capture or delta-sigma; unit zero also as event counter.
// (R2) Unit clock is the system clock, selected as the 16 or 32 MHz rate.
// (R3) Five-bit prescale: zero passes the clock, otherwise divides by two to its power, values above 16 acting as 16.
// (R4) Each unit has a 17-bit up counter plus 17-bit rise and fall registers.
// (R5) With gating on, the counter holds while the gate input is high.
// (R6) Counter equal to rise or fall can interrupt, each separately maskable.
// (R7) Six pulse-only timers lack event counting, capture and external gating.
// (R8) PWM output rises at the rise match and falls at the fall match.
// (R9) Continuous PWM restarts from zero at fall; single shot makes one pulse.
// (R10) New rise or fall values in continuous PWM apply after the current cycle.
// (R11) The waveform reaches its pin only while that pin's driver is enabled.
// (R12) Capture stores count at next rising edge in rise, following falling edge in fall.
// (R13) Software reading the capture registers stops the counter.
// (R14) Captures count from mode start and each edge overwrites, keeping the latest pulse.
// (R15) Timer mode runs single or repeating, period in fall, interrupting at fall match.
// (R16) Only unit zero counts events from the gate pin on chosen edges, up to fall.
// (R17) External event edges arrive at least 100 ns apart.
// (R18) Delta-sigma NRZ is high for the high-register count of clocks per 2^17 clocks.
// (R19) The pulse pattern differs between conversion cycles for the same value.
// (R20) Delta-sigma RTZ is low every other clock; the cycle is 2^18 clocks.
// (R21) Each pin use is enabled separately; plain timer mode needs no pins.
// (R22) Pulse placement compares a maximal 17-bit LFSR against the high register.
// (R23) Matches set sticky flags that software clears; interrupt ORs enabled flags.
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
`include "timer_consts.svh"

module multimode_timer_pwm_unit
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              resetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [`ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Input pins
   input  wire logic              gate_event_input,
   input  wire logic              capture_input_zero,
   input  wire logic              capture_input_one,
   // Waveform pins
   output logic                   wave_output_zero,
   output logic                   wave_output_one,
   output logic                   pulse_out_one,
   output logic                   pulse_out_two,
   output logic                   pulse_out_three,
   output logic                   pulse_out_four,
   output logic                   pulse_out_five,
   output logic                   pulse_out_six,
   output logic [`NUM_UNITS-1:0]  wave_oe,
   // Interrupt
   output logic                   irq
);

   state_t s_r;
   state_t s_nxt;

   logic [2:0]          mode;
   logic [4:0]          ep;
   logic [`CNT_W-1:0]   mask;
   logic [`CNT_W-1:0]   cn;
   logic [`CNT_W-1:0]   lf;
   logic [`CNT_W-1:0]   cnt_cur;
   logic                full;
   logic                tick;
   logic                hold;
   logic                adv;
   logic                cmp;
   logic                hit_r;
   logic                hit_f;
   logic                cap_r;
   logic                cap_f;
   logic                ev_rise;
   logic                ev_fall;
   logic                c0_rise;
   logic                c0_fall;
   logic                c1_rise;
   logic                c1_fall;
   logic                wr;
   logic                rd;
   logic                here;
   logic                setup;
   logic                ofs_ok;
   logic                irq_n;
   logic [2:0]          sel;
   logic [4:0]          ofs;
   logic [31:0]         rdat;
   logic [`CTRL_W-1:0]  ctl;

   always_comb begin
      mode    = `MODE_TIMER;
      ep      = '0;
      mask    = '0;
      cn      = '0;
      lf      = '0;
      cnt_cur = '0;
      full    = 1'b0;
      tick    = 1'b0;
      hold    = 1'b0;
      adv     = 1'b0;
      cmp     = 1'b0;
      hit_r   = 1'b0;
      hit_f   = 1'b0;
      cap_r   = 1'b0;
      cap_f   = 1'b0;
      here    = 1'b0;
      irq_n   = 1'b0;
      ctl     = '0;
      s_nxt   = s_r;

      // Pins are asynchronous; edges are only taken from the second and third stages.
      s_nxt.gate_s = {s_r.gate_s[1:0], gate_event_input};
      s_nxt.cap0_s = {s_r.cap0_s[1:0], capture_input_zero};
      s_nxt.cap1_s = {s_r.cap1_s[1:0], capture_input_one};
      // At 50 ns per clock two samples fit between event edges, so none is missed.
      ev_rise = s_r.gate_s[1] & ~s_r.gate_s[2]; // R17
      ev_fall = ~s_r.gate_s[1] & s_r.gate_s[2]; // R17
      c0_rise = s_r.cap0_s[1] & ~s_r.cap0_s[2];
      c0_fall = ~s_r.cap0_s[1] & s_r.cap0_s[2];
      c1_rise = s_r.cap1_s[1] & ~s_r.cap1_s[2];
      c1_fall = ~s_r.cap1_s[1] & s_r.cap1_s[2];

      sel    = paddr[7:5];
      ofs    = paddr[4:0];
      setup  = psel & ~penable;
      ofs_ok = (ofs == `OFS_CTRL) || (ofs == `OFS_PRESC) || (ofs == `OFS_RISE) ||
               (ofs == `OFS_FALL) || (ofs == `OFS_COUNT) || (ofs == `OFS_STAT);
      wr     = psel & penable & s_r.pready & ~s_r.pslverr & pwrite;
      rd     = psel & penable & s_r.pready & ~s_r.pslverr & ~pwrite;

      for (int i = 0; i < `NUM_UNITS; i++) begin
         full = (i < `FULL_UNITS); // R1
         ctl  = s_r.u[i].ctrl;
         mode = ctl[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
         // Counting and capture modes are unavailable where the hardware lacks them.
         if ((i != 0 && mode == `MODE_COUNTER) || (!full && mode == `MODE_CAPTURE)) begin
            mode = `MODE_TIMER; // R7 R16
         end

         // The 16 MHz selection adds one halving stage to the prescaler.
         ep = (s_r.u[i].presc > `PRESC_MAX) ? `PRESC_MAX : s_r.u[i].presc; // R3
         ep = ep + {4'h0, ~ctl[`CTRL_SYS32]}; // R2
         mask = `CNT_W'(({1'b0, {`CNT_W{1'b0}}} | 18'h1) << ep) - `CNT_W'(1); // R3
         tick = (s_r.u[i].div & mask) == mask; // R3
         s_nxt.u[i].div = s_r.u[i].div + `CNT_W'(1);

         hold = full && ctl[`CTRL_GATE] && ctl[`CTRL_IN_EN] && s_r.gate_s[2]; // R5 R7 R21
         if (mode == `MODE_COUNTER) begin
            adv = ctl[`CTRL_IN_EN] &
                  ((ctl[`CTRL_EDGE_RISE] & ev_rise) | (ctl[`CTRL_EDGE_FALL] & ev_fall)); // R16 R21
         end else begin
            adv = tick & ~hold; // R5
         end

         cap_r = ctl[`CTRL_IN_EN] & ((i == 0) ? c0_rise : ((i == 1) ? c1_rise : 1'b0)); // R21
         cap_f = ctl[`CTRL_IN_EN] & ((i == 0) ? c0_fall : ((i == 1) ? c1_fall : 1'b0)); // R21

         lf  = {s_r.u[i].lfsr[`CNT_W-2:0],
                s_r.u[i].lfsr[`LFSR_TAP_HI] ^ s_r.u[i].lfsr[`LFSR_TAP_LO]}; // R22
         // The sequence skips zero, so subtracting one yields exactly rise hits per period.
         cmp = (s_r.u[i].lfsr - `CNT_W'(1)) < s_r.u[i].rise; // R22 R18
         cn  = s_r.u[i].cnt + `CNT_W'(1); // R4
         hit_r = 1'b0;
         hit_f = 1'b0;

         if (s_r.u[i].running && adv) begin
            unique case (mode)
               `MODE_DS_NRZ: begin
                  // The 2^17-1 sequence beats against the 2^17 frame, shifting each pattern.
                  s_nxt.u[i].lfsr = lf; // R19
                  s_nxt.u[i].wave = cmp; // R18
                  s_nxt.u[i].cnt  = cn; // R18
               end
               `MODE_DS_RTZ: begin
                  s_nxt.u[i].phase = ~s_r.u[i].phase; // R20
                  if (!s_r.u[i].phase) begin
                     s_nxt.u[i].lfsr = lf; // R19
                     s_nxt.u[i].wave = cmp; // R20
                  end else begin
                     s_nxt.u[i].wave = 1'b0; // R20
                     s_nxt.u[i].cnt  = cn; // R20
                  end
               end
               `MODE_CAPTURE: begin
                  s_nxt.u[i].cnt = cn; // R14
               end
               default: begin
                  s_nxt.u[i].cnt = cn;
                  if (cn == s_r.u[i].fall_act) begin
                     hit_f = 1'b1; // R6 R15 R16
                     s_nxt.u[i].wave = 1'b0; // R8
                     if (ctl[`CTRL_REPEAT]) begin
                        s_nxt.u[i].cnt      = '0; // R9
                        s_nxt.u[i].rise_act = s_r.u[i].rise; // R10
                        s_nxt.u[i].fall_act = s_r.u[i].fall; // R10
                     end else begin
                        s_nxt.u[i].running = 1'b0; // R9 R15
                     end
                  end else if (cn == s_r.u[i].rise_act) begin
                     hit_r = 1'b1; // R6
                     if (mode == `MODE_PWM) begin
                        s_nxt.u[i].wave = 1'b1; // R8
                     end
                  end
               end
            endcase
         end

         // Each edge overwrites, so only the latest pulse survives.
         if (s_r.u[i].running && mode == `MODE_CAPTURE) begin
            cnt_cur = s_r.u[i].cnt;
            if (cap_r) begin
               s_nxt.u[i].rise = cnt_cur; // R12 R14
               hit_r = 1'b1;
            end
            if (cap_f) begin
               s_nxt.u[i].fall = cnt_cur; // R12 R14
               hit_f = 1'b1;
            end
         end

         here = (sel == 3'(i));
         if (wr && here) begin
            unique case (ofs)
               `OFS_CTRL: begin
                  s_nxt.u[i].ctrl    = pwdata[`CTRL_W-1:0];
                  s_nxt.u[i].running = pwdata[`CTRL_START];
                  // Writing start always restarts, so capture counts from this point.
                  if (pwdata[`CTRL_START]) begin
                     s_nxt.u[i].cnt      = '0; // R14
                     s_nxt.u[i].div      = '0;
                     s_nxt.u[i].rise_act = s_r.u[i].rise;
                     s_nxt.u[i].fall_act = s_r.u[i].fall;
                     s_nxt.u[i].wave     = 1'b0;
                     s_nxt.u[i].phase    = 1'b0;
                     s_nxt.u[i].lfsr     = `LFSR_SEED; // R22
                  end
               end
               `OFS_PRESC: s_nxt.u[i].presc = pwdata[`PRESC_W-1:0];
               `OFS_RISE:  s_nxt.u[i].rise  = pwdata[`CNT_W-1:0];
               `OFS_FALL:  s_nxt.u[i].fall  = pwdata[`CNT_W-1:0];
               default: begin
               end
            endcase
         end

         if (rd && here && mode == `MODE_CAPTURE && (ofs == `OFS_RISE || ofs == `OFS_FALL)) begin
            s_nxt.u[i].running = 1'b0; // R13
         end

         // A match in the clearing cycle keeps its flag.
         s_nxt.u[i].flag_rise = (s_r.u[i].flag_rise &
                                 ~(wr && here && ofs == `OFS_STAT && pwdata[`STAT_RISE])) | hit_r; // R23
         s_nxt.u[i].flag_fall = (s_r.u[i].flag_fall &
                                 ~(wr && here && ofs == `OFS_STAT && pwdata[`STAT_FALL])) | hit_f; // R23
         irq_n = irq_n |
                 (s_nxt.u[i].flag_rise & s_nxt.u[i].ctrl[`CTRL_IE_RISE]) |
                 (s_nxt.u[i].flag_fall & s_nxt.u[i].ctrl[`CTRL_IE_FALL]); // R6 R23

         s_nxt.pin[i] = s_nxt.u[i].wave & s_nxt.u[i].ctrl[`CTRL_OUT_EN]; // R11 R21
         s_nxt.oe[i]  = s_nxt.u[i].ctrl[`CTRL_OUT_EN]; // R11 R21
      end
      s_nxt.irq = irq_n;

      unique case (ofs)
         `OFS_CTRL: begin
            rdat = 32'(s_r.u[sel].ctrl);
            rdat[`CTRL_START] = s_r.u[sel].running;
         end
         `OFS_PRESC: rdat = 32'(s_r.u[sel].presc);
         `OFS_RISE:  rdat = 32'(s_r.u[sel].rise);
         `OFS_FALL:  rdat = 32'(s_r.u[sel].fall);
         `OFS_COUNT: rdat = 32'(s_r.u[sel].cnt);
         `OFS_STAT:  rdat = {28'h0, s_r.u[sel].wave, s_r.u[sel].running,
                             s_r.u[sel].flag_fall, s_r.u[sel].flag_rise};
         default:    rdat = 32'h0;
      endcase

      // Answer is prepared in the setup cycle, so every access takes exactly two cycles.
      s_nxt.pready = setup;
      if (setup) begin
         s_nxt.pslverr = ~ofs_ok;
         s_nxt.prdata  = ofs_ok ? rdat : 32'h0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata           = s_r.prdata;
   assign pready           = s_r.pready;
   assign pslverr          = s_r.pslverr;
   assign wave_output_zero = s_r.pin[0];
   assign wave_output_one  = s_r.pin[1];
   assign pulse_out_one    = s_r.pin[2];
   assign pulse_out_two    = s_r.pin[3];
   assign pulse_out_three  = s_r.pin[4];
   assign pulse_out_four   = s_r.pin[5];
   assign pulse_out_five   = s_r.pin[6];
   assign pulse_out_six    = s_r.pin[7];
   assign wave_oe          = s_r.oe;
   assign irq              = s_r.irq;

endmodule

/* rtl/timer_consts.svh */
// Constants for the multimode timer and pulse unit: offsets, field positions, codes and counts.
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

`define CNT_W          17
`define CTRL_W         13
`define PRESC_W        5
`define NUM_UNITS      8
`define FULL_UNITS     2
`define ADDR_W         8

// Register offsets inside one unit's 32-byte window; unit index is paddr[7:5].
`define OFS_CTRL       5'h00
`define OFS_PRESC      5'h04
`define OFS_RISE       5'h08
`define OFS_FALL       5'h0c
`define OFS_COUNT      5'h10
`define OFS_STAT       5'h14

// Control register fields.
`define CTRL_START     0
`define CTRL_REPEAT    1
`define CTRL_MODE_LSB  2
`define CTRL_MODE_MSB  4
`define CTRL_GATE      5
`define CTRL_OUT_EN    6
`define CTRL_IN_EN     7
`define CTRL_EDGE_RISE 8
`define CTRL_EDGE_FALL 9
`define CTRL_IE_RISE   10
`define CTRL_IE_FALL   11
`define CTRL_SYS32     12

// Status register fields.
`define STAT_RISE      0
`define STAT_FALL      1
`define STAT_RUN       2
`define STAT_WAVE      3

// Mode codes.
`define MODE_TIMER     3'h0
`define MODE_COUNTER   3'h1
`define MODE_PWM       3'h2
`define MODE_CAPTURE   3'h3
`define MODE_DS_NRZ    3'h4
`define MODE_DS_RTZ    3'h5

`define PRESC_MAX      5'h10
`define LFSR_SEED      17'h00001
`define LFSR_TAP_HI    16
`define LFSR_TAP_LO    13

`endif

/* rtl/timer_pkg.sv */
// Types shared by the multimode timer and pulse unit.
package timer_pkg;
`include "timer_consts.svh"

   typedef struct packed {
      logic [`CNT_W-1:0]   cnt;
      logic [`CNT_W-1:0]   rise;
      logic [`CNT_W-1:0]   fall;
      logic [`CNT_W-1:0]   rise_act;
      logic [`CNT_W-1:0]   fall_act;
      logic [`CNT_W-1:0]   div;
      logic [`CNT_W-1:0]   lfsr;
      logic [`CTRL_W-1:0]  ctrl;
      logic [`PRESC_W-1:0] presc;
      logic                running;
      logic                phase;
      logic                flag_rise;
      logic                flag_fall;
      logic                wave;
   } unit_t;

   typedef struct packed {
      unit_t [`NUM_UNITS-1:0] u;
      logic [2:0]             gate_s;
      logic [2:0]             cap0_s;
      logic [2:0]             cap1_s;
      logic                   pready;
      logic                   pslverr;
      logic [31:0]            prdata;
      logic [`NUM_UNITS-1:0]  pin;
      logic [`NUM_UNITS-1:0]  oe;
      logic                   irq;
   } state_t;

endpackage

/* tb/multimode_timer_pwm_unit_checker.sv */
// Port-side assertions for the timer and pulse unit.
`timescale 1ns/10ps
`include "timer_consts.svh"
module multimode_timer_pwm_unit_checker
   import timer_pkg::*;
(
   // Clock and bus
   input wire logic                  core_clk,
   input wire logic                  resetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [`ADDR_W-1:0]    paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   // Pins and interrupt
   input wire logic                  wave_output_zero,
   input wire logic                  wave_output_one,
   input wire logic                  pulse_out_one,
   input wire logic                  pulse_out_two,
   input wire logic [`NUM_UNITS-1:0] wave_oe,
   input wire logic                  irq
);
   logic [7:0] oe_r;
   logic [7:0] ie_r;
   logic [3:0] pins;
   assign pins = {pulse_out_two, pulse_out_one, wave_output_one, wave_output_zero};
   // Shadow of the enables, updated at the same access edge as the design's own copy.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         oe_r <= 8'h00;
         ie_r <= 8'h00;
      end else if (psel && penable && pready && pwrite && paddr[4:0] == `OFS_CTRL) begin
         oe_r[paddr[7:5]] <= pwdata[`CTRL_OUT_EN];
         ie_r[paddr[7:5]] <= pwdata[`CTRL_IE_RISE] | pwdata[`CTRL_IE_FALL];
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   property p_ready_after_setup;
      psel && !penable |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("no pready after setup");
   property p_ready_cause;
      pready |-> $past(psel && !penable);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("pready without setup");
   property p_err_decode;
      pready |-> pslverr == (paddr[4:3] == 2'b11);
   endproperty
   a_err_decode: assert property (p_err_decode) else $error("wrong pslverr");
   property p_rdata_hold;
      !(psel && !penable) |=> $stable(prdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("prdata moved");
   property p_reset_quiet;
      $rose(resetn) |-> wave_oe == 8'h00 && !irq;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
   property p_pin_gated;
      (pins & ~wave_oe[3:0]) == 4'h0;
   endproperty
   a_pin_gated: assert property (p_pin_gated) else $error("pin high while disabled");
   property p_oe_follows;
      wave_oe == oe_r;
   endproperty
   a_oe_follows: assert property (p_oe_follows) else $error("wave_oe not per unit");
   property p_irq_masked;
      irq |-> ie_r != 8'h00 || $past(ie_r) != 8'h00;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
   c_irq: cover property ($rose(irq));
   c_err: cover property (pready && pslverr);
   c_pwm: cover property ($fell(pulse_out_two));
endmodule

bind multimode_timer_pwm_unit multimode_timer_pwm_unit_checker i_multimode_timer_pwm_unit_checker (
   .core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .wave_output_zero, .wave_output_one, .pulse_out_one, .pulse_out_two, .wave_oe, .irq);

/* tb/multimode_timer_pwm_unit_test.sv */
// Self-checking bench for the timer and pulse unit.
`timescale 1ns/10ps
`include "timer_consts.svh"
module multimode_timer_pwm_unit_test;
   import timer_pkg::*;
   logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr, irq, er;
   logic        gate_event_input, capture_input_zero, capture_input_one;
   logic [7:0]  paddr, pins, wave_oe;
   logic [31:0] pwdata, prdata, rd, dv;
   logic [15:0] lf;
   int          num_errors, total_checks, f, p, r, w, h, l, n, ex, ones, prs, prev;
   multimode_timer_pwm_unit i_multimode_timer_pwm_unit (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .gate_event_input, .capture_input_zero, .capture_input_one,
      .wave_output_zero(pins[0]), .wave_output_one(pins[1]), .pulse_out_one(pins[2]), .pulse_out_two(pins[3]),
      .pulse_out_three(pins[4]), .pulse_out_four(pins[5]), .pulse_out_five(pins[6]),
      .pulse_out_six(pins[7]), .wave_oe, .irq);
   timer_pin_source i_timer_pin_source (.core_clk, .gate_event_input, .capture_input_zero, .capture_input_one);
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   function automatic int rnd(input int m);
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf % m;
   endfunction
   function automatic logic [7:0] ad(input int u, input logic [4:0] o);
      return {u[2:0], o};
   endfunction
   task automatic end_sim;
      if (num_errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      repeat (16) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      if (pready !== 1'b1) begin
         num_errors++;
         end_sim();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   // Measures one run of level v on the second pulse-only pin, in clocks.
   task automatic run_len(input logic v, output int len);
      len = 0;
      for (int i = 0; i < 400 && pins[3] !== v; i++) @(posedge core_clk);
      while (pins[3] === v && len < 400) begin
         @(posedge core_clk);
         len++;
      end
   endtask
   initial begin
      {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
      lf = 16'h916a;
      num_errors = 0;
      total_checks = 0;
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      for (int u = 0; u < 8; u++) begin
         for (int o = 0; o < 8; o++) begin
            apb(1'b0, ad(u, {o[2:0], 2'b00}), 32'h0);
            chk(rd, 32'h0);
            chk(er, o > 5);
         end
         dv = rnd(65536) * 65536 + rnd(65536);
         apb(1'b1, ad(u, `OFS_RISE), dv);
         apb(1'b0, ad(u, `OFS_RISE), 32'h0);
         chk(rd, dv & 32'h1ffff);
         apb(1'b1, ad(u, `OFS_COUNT), dv);
         apb(1'b0, ad(u, `OFS_COUNT), 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b1, ad(1, `OFS_RISE), 32'h0);
      for (int k = 0; k < 4; k++) begin
         f = 3 + rnd(6);
         p = rnd(4);
         ex = f << (p + (k % 2 == 0));
         apb(1'b1, ad(1, `OFS_FALL), f);
         apb(1'b1, ad(1, `OFS_PRESC), p);
         apb(1'b1, ad(1, `OFS_CTRL), 32'h1 | ((k % 2) << 12) | ((k < 2) << 11) | ((k == 1) << 1));
         n = 0;
         while (irq !== 1'b1 && n < ex + 8) begin
            @(posedge core_clk);
            n++;
         end
         chk((k > 1) ? irq : (n >= ex && n <= ex + 2), k < 2);
         apb(1'b0, ad(1, `OFS_STAT), 32'h0);
         chk(rd, (k == 1) ? 32'h6 : 32'h2);
         apb(1'b1, ad(1, `OFS_CTRL), 32'h0);
         apb(1'b1, ad(1, `OFS_STAT), 32'h3);
         apb(1'b0, ad(1, `OFS_STAT), 32'h0);
         chk(rd | irq, 32'h0);
      end
      apb(1'b1, ad(0, `OFS_CTRL), 32'h108d);
      w = 6 + rnd(8);
      i_timer_pin_source.pulse(1, 5, w);
      i_timer_pin_source.pulse(1, 4, w + 3);
      repeat (6) @(posedge core_clk);
      apb(1'b0, ad(0, `OFS_RISE), 32'h0);
      h = rd;
      apb(1'b0, ad(0, `OFS_FALL), 32'h0);
      chk(rd - h, w + 3);
      chk(h >= w + 9, 1);
      apb(1'b0, ad(0, `OFS_COUNT), 32'h0);
      l = rd;
      repeat (5) @(posedge core_clk);
      apb(1'b0, ad(0, `OFS_COUNT), 32'h0);
      chk(rd, l);
      apb(1'b1, ad(0, `OFS_STAT), 32'h3);
      for (int e = 1; e < 4; e++) begin
         n = 2 + rnd(3);
         ex = (e == 3) ? 2 * n : n;
         apb(1'b1, ad(0, `OFS_FALL), ex);
         apb(1'b1, ad(0, `OFS_CTRL), 32'h1085 | (e << 8));
         repeat (n) i_timer_pin_source.pulse(0, 3, 3);
         repeat (8) @(posedge core_clk);
         apb(1'b0, ad(0, `OFS_COUNT), 32'h0);
         chk(rd, ex);
         apb(1'b0, ad(0, `OFS_STAT), 32'h0);
         chk(rd, 32'h2);
         apb(1'b1, ad(0, `OFS_STAT), 32'h3);
      end
      apb(1'b1, ad(1, `OFS_PRESC), 32'h0);
      apb(1'b1, ad(1, `OFS_FALL), 32'h1ffff);
      apb(1'b1, ad(1, `OFS_CTRL), 32'h10a1);
      i_timer_pin_source.set_pin(0, 1'b1);
      repeat (4) @(posedge core_clk);
      apb(1'b0, ad(1, `OFS_COUNT), 32'h0);
      h = rd;
      repeat (10) @(posedge core_clk);
      apb(1'b0, ad(1, `OFS_COUNT), 32'h0);
      chk(rd, h);
      i_timer_pin_source.set_pin(0, 1'b0);
      repeat (10) @(posedge core_clk);
      apb(1'b0, ad(1, `OFS_COUNT), 32'h0);
      chk(rd > h, 1);
      r = 2 + rnd(5);
      f = r + 5 + rnd(4);
      apb(1'b1, ad(3, `OFS_RISE), r);
      apb(1'b1, ad(3, `OFS_FALL), f);
      apb(1'b1, ad(3, `OFS_CTRL), 32'h104b);
      run_len(1'b1, h);
      chk(h, f - r);
      run_len(1'b0, l);
      chk(l, r);
      fork
         apb(1'b1, ad(3, `OFS_FALL), f + 4);
         run_len(1'b1, h);
      join
      chk(h, f - r);
      run_len(1'b0, l);
      run_len(1'b1, h);
      chk(h, f + 4 - r);
      apb(1'b1, ad(3, `OFS_CTRL), 32'h100b);
      n = 0;
      repeat (3 * f) begin
         @(posedge core_clk);
         n += pins[3];
      end
      chk(n, 0);
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, ad(2, `OFS_RISE), (k == 2) ? 32'h0 : 32'h10000);
         apb(1'b1, ad(2, `OFS_CTRL), 32'h1041 | (((k == 1) ? 5 : 4) << 2));
         {ones, prs, prev} = '0;
         repeat (4096) begin
            @(posedge core_clk);
            ones += pins[2];
            prs += pins[2] & prev;
            prev = pins[2];
         end
         ex = (k == 2) ? 0 : 2048 >> k;
         chk(ones >= ex - ex / 4 && ones <= ex + ex / 4, 1);
         chk(prs == 0, k != 0);
      end
      end_sim();
   end
endmodule

/* tb/timer_pin_source.sv */
// Far-side model: the gate/event pin and the two capture pins.
`timescale 1ns/10ps
module timer_pin_source (
   // Clock
   input  wire logic core_clk,
   // Driven pins
   output logic      gate_event_input,
   output logic      capture_input_zero,
   output logic      capture_input_one
);
   logic [2:0] pin_r;
   assign {capture_input_one, capture_input_zero, gate_event_input} = pin_r;
   initial pin_r = 3'h0;
   task automatic set_pin(input int idx, input logic v);
      @(posedge core_clk);
      pin_r[idx] <= v;
   endtask
   // Every level is held at least three clocks, so edges are always more than 100 ns apart.
   task automatic pulse(input int idx, input int lo, input int hi);
      repeat ((lo < 3) ? 3 : lo) @(posedge core_clk);
      pin_r[idx] <= 1'b1;
      repeat ((hi < 3) ? 3 : hi) @(posedge core_clk);
      pin_r[idx] <= 1'b0;
   endtask
endmodule
